/* File: hdl/pwm_timer_pkg.sv */
// Constants for the sixteen-bit fast and phase-correct PWM timer.
// Assumes a single core clock and a register port with byte addresses.
package pwm_timer_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 2;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CMP_A = 8'h04;
  localparam logic [7:0] OFS_CMP_B = 8'h08;
  localparam logic [7:0] OFS_CAPTURE_TOP = 8'h0C;
  localparam logic [7:0] OFS_COUNTER = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;

  // ---------------------------------------------------------------
  // Control field layout
  // ---------------------------------------------------------------
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_ACT_A_LSB = 4;
  localparam int CTL_ACT_B_LSB = 6;
  localparam int CTL_DIR_LSB = 8;

  // ---------------------------------------------------------------
  // Flag bit positions
  // ---------------------------------------------------------------
  localparam int FLG_OVERFLOW = 0;
  localparam int FLG_CAPTURE = 1;
  localparam int FLG_CMP_LSB = 2;
  localparam int FLG_W = 4;

  // ---------------------------------------------------------------
  // Waveform mode select codes
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_PC_8 = 4'h1;
  localparam logic [3:0] MODE_PC_9 = 4'h2;
  localparam logic [3:0] MODE_PC_10 = 4'h3;
  localparam logic [3:0] MODE_FAST_8 = 4'h5;
  localparam logic [3:0] MODE_FAST_9 = 4'h6;
  localparam logic [3:0] MODE_FAST_10 = 4'h7;
  localparam logic [3:0] MODE_PC_CAP = 4'hA;
  localparam logic [3:0] MODE_PC_CMPA = 4'hB;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hF;

  // ---------------------------------------------------------------
  // Fixed TOP values and output actions
  // ---------------------------------------------------------------
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] FULL_MASK = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

endpackage

/* File: hdl/pwm_timer.sv */
// Sixteen-bit timer with fast PWM and phase-correct PWM waveform output.
// Assumes timer_tick is a one-cycle enable made on core_clk by a prescaler.
//
// What this block does
// R1 - Fast PWM counts zero to TOP, restarts
// R2 - Fast TOP: fixed, capture or channel A
// R3 - Fast: action 2 clears on match, 3 sets
// R4 - Fast overflow at TOP, plus TOP-source flag
// R5 - Compare flag set when counter equals compare
// R6 - Fixed TOP masks high compare bits on write
// R7 - Capture TOP unbuffered; low value wraps counter
// R8 - Compare buffers load at TOP in fast
// R9 - Software keeps TOP at or above compares
// R10 - Software keeps register TOP at least three
// R11 - Fast extremes: zero spikes, TOP constant
// R12 - Fast mode 15 action 1 toggles A
// R13 - Pin driven only when direction selects output
// R14 - Phase-correct counts up then down
// R15 - Phase TOP sources; TOP held one tick
// R16 - Phase: clear rising match, set falling
// R17 - Phase overflow at zero, loads at TOP
// R18 - Phase extremes: zero low, TOP high
// R19 - Phase mode 11 action 1 toggles A
// R20 - Software prefers frequency-correct for TOP changes
// R21 - Reset clears compare output states
// R22 - Action 0 changes nothing; new action next match
// R23 - Counting advances only on timer tick
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module pwm_timer
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic timer_tick,
  input wire logic [pwm_timer_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pwm_timer_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pwm_timer_pkg::DATA_W-1:0] reg_rdata,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe
);
  import pwm_timer_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] waveform_mode_select;
    logic [NUM_CH-1:0][1:0] compare_output_action;
    logic [NUM_CH-1:0] pin_direction_bit;
    logic [NUM_CH-1:0][CNT_W-1:0] compare_buf;
    logic [NUM_CH-1:0][CNT_W-1:0] compare_value;
    logic [CNT_W-1:0] capture_top_value;
    logic [CNT_W-1:0] counter_value;
    logic count_up;
    logic [FLG_W-1:0] flags;
    logic [NUM_CH-1:0] compare_output_state;
    logic [NUM_CH-1:0] pin_oe;
    logic [DATA_W-1:0] rdata;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic is_fast;
  logic is_phase;
  logic top_from_cap;
  logic top_from_cmpa;
  logic [CNT_W-1:0] top_value;
  logic [CNT_W-1:0] write_mask;
  logic at_top;
  logic at_zero;
  logic rising;
  logic [NUM_CH-1:0] hit;
  logic [FLG_W-1:0] flag_set;
  logic [FLG_W-1:0] flag_clr;
  logic load_cmp;

  // ---------------------------------------------------------------
  // Waveform action for one channel
  // ---------------------------------------------------------------
  // Applying the wrap action after the match makes a compare equal to TOP
  // hold one level for ever, and a compare of zero give a one-tick spike.
  function automatic logic wave_step(input logic cur, input logic [1:0] act, input logic match,
                                     input logic wrap, input logic up, input logic fast,
                                     input logic toggle_ok);
    logic r;
    r = cur;
    if (act == ACT_TOGGLE && toggle_ok && match)
    begin
      r = ~cur; // [R12] [R19]
    end
    else if (act == ACT_CLEAR || act == ACT_SET)
    begin
      if (fast)
      begin
        if (match)
        begin
          r = (act == ACT_SET); // [R3]
        end
        if (wrap)
        begin
          r = (act == ACT_CLEAR); // [R3] [R11]
        end
      end
      else if (match)
      begin
        r = up ? (act == ACT_SET) : (act == ACT_CLEAR); // [R16] [R18]
      end
    end
    return r; // [R22]
  endfunction

  // ---------------------------------------------------------------
  // Mode decode and TOP selection
  // ---------------------------------------------------------------
  always_comb
  begin
    is_fast = state_reg.waveform_mode_select inside {MODE_FAST_8, MODE_FAST_9, MODE_FAST_10,
        MODE_FAST_CAP, MODE_FAST_CMPA};
    is_phase = state_reg.waveform_mode_select inside {MODE_PC_8, MODE_PC_9, MODE_PC_10,
        MODE_PC_CAP, MODE_PC_CMPA};
    top_from_cap = 1'b0;
    top_from_cmpa = 1'b0;
    top_value = FULL_MASK;
    write_mask = FULL_MASK;
    unique case (state_reg.waveform_mode_select)
      MODE_FAST_8, MODE_PC_8:
      begin
        top_value = TOP_8BIT;
        write_mask = TOP_8BIT; // [R6]
      end
      MODE_FAST_9, MODE_PC_9:
      begin
        top_value = TOP_9BIT;
        write_mask = TOP_9BIT; // [R6]
      end
      MODE_FAST_10, MODE_PC_10:
      begin
        top_value = TOP_10BIT;
        write_mask = TOP_10BIT; // [R6]
      end
      MODE_FAST_CAP, MODE_PC_CAP:
      begin
        top_value = state_reg.capture_top_value; // [R2] [R15] [R7]
        top_from_cap = 1'b1;
      end
      MODE_FAST_CMPA, MODE_PC_CMPA:
      begin
        top_value = state_reg.compare_value[0]; // [R2] [R15]
        top_from_cmpa = 1'b1;
      end
      default:
      begin
        top_value = FULL_MASK;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    at_top = (state_reg.counter_value == top_value);
    at_zero = (state_reg.counter_value == COUNT_ZERO);
    // Direction seen by a match: zero counts as rising, TOP as falling
    rising = at_zero ? 1'b1 : (at_top ? 1'b0 : state_reg.count_up);
    flag_set = '0;
    flag_clr = '0;
    load_cmp = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      hit[i] = (is_fast || is_phase) && (state_reg.counter_value == state_reg.compare_value[i]);
    end
    if (timer_tick && (is_fast || is_phase)) // [R23]
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (hit[i])
        begin
          flag_set[FLG_CMP_LSB + i] = 1'b1; // [R5]
        end
        state_next.compare_output_state[i] = wave_step(state_reg.compare_output_state[i],
            state_reg.compare_output_action[i], hit[i], is_fast && at_top, rising, is_fast,
            (i == 0) && top_from_cmpa);
      end
      if (is_fast)
      begin
        if (at_top)
        begin
          state_next.counter_value = COUNT_ZERO; // [R1] [R2]
          flag_set[FLG_OVERFLOW] = 1'b1; // [R4]
          flag_set[FLG_CAPTURE] = top_from_cap; // [R4]
          load_cmp = 1'b1; // [R8]
        end
        else
        begin
          // Plain 16-bit increment wraps through 0xFFFF when TOP was passed
          state_next.counter_value = state_reg.counter_value + COUNT_ONE; // [R1] [R7]
        end
      end
      else if (at_top && state_reg.count_up)
      begin
        state_next.counter_value = state_reg.counter_value - COUNT_ONE; // [R14] [R15]
        state_next.count_up = 1'b0;
        flag_set[FLG_CAPTURE] = top_from_cap; // [R17]
        load_cmp = 1'b1; // [R17]
      end
      else if (at_zero && !state_reg.count_up)
      begin
        state_next.counter_value = COUNT_ONE; // [R14]
        state_next.count_up = 1'b1;
        flag_set[FLG_OVERFLOW] = 1'b1; // [R17]
      end
      else if (state_reg.count_up)
      begin
        state_next.counter_value = state_reg.counter_value + COUNT_ONE; // [R14]
      end
      else
      begin
        state_next.counter_value = state_reg.counter_value - COUNT_ONE; // [R14]
      end
    end
    if (load_cmp || !(is_fast || is_phase))
    begin
      state_next.compare_value = state_reg.compare_buf; // [R8] [R17]
    end
    if (!is_phase)
    begin
      state_next.count_up = 1'b1;
    end

    // Register writes; the action field acts on the next match, or in fast mode on the next TOP if that comes first
    if (reg_wr)
    begin
      unique case (reg_addr)
        OFS_CONTROL:
        begin
          state_next.waveform_mode_select = reg_wdata[CTL_MODE_LSB +: 4];
          state_next.compare_output_action[0] = reg_wdata[CTL_ACT_A_LSB +: 2]; // [R22]
          state_next.compare_output_action[1] = reg_wdata[CTL_ACT_B_LSB +: 2]; // [R22]
          state_next.pin_direction_bit = reg_wdata[CTL_DIR_LSB +: NUM_CH];
        end
        OFS_CMP_A: state_next.compare_buf[0] = reg_wdata[CNT_W-1:0] & write_mask; // [R6] [R8]
        OFS_CMP_B: state_next.compare_buf[1] = reg_wdata[CNT_W-1:0] & write_mask; // [R6]
        OFS_CAPTURE_TOP: state_next.capture_top_value = reg_wdata[CNT_W-1:0]; // [R7]
        OFS_FLAGS: flag_clr = reg_wdata[FLG_W-1:0];
        default: flag_clr = '0;
      endcase
    end
    // A flag raised in the cycle it is cleared stays set
    state_next.flags = (state_reg.flags & ~flag_clr) | flag_set;

    // Pin drive: waveform reaches the pin only with direction set to output
    for (int i = 0; i < NUM_CH; i++)
    begin
      state_next.pin_oe[i] = state_next.pin_direction_bit[i] &&
          (state_next.compare_output_action[i][1] ||
           (state_next.compare_output_action[i] == ACT_TOGGLE && i == 0 &&
            state_next.waveform_mode_select inside {MODE_FAST_CMPA, MODE_PC_CMPA})); // [R13]
    end

    // Read data stands in the cycle after the strobe only
    state_next.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_CONTROL:
        begin
          state_next.rdata[CTL_MODE_LSB +: 4] = state_reg.waveform_mode_select;
          state_next.rdata[CTL_ACT_A_LSB +: 2] = state_reg.compare_output_action[0];
          state_next.rdata[CTL_ACT_B_LSB +: 2] = state_reg.compare_output_action[1];
          state_next.rdata[CTL_DIR_LSB +: NUM_CH] = state_reg.pin_direction_bit;
        end
        OFS_CMP_A: state_next.rdata[CNT_W-1:0] = state_reg.compare_buf[0];
        OFS_CMP_B: state_next.rdata[CNT_W-1:0] = state_reg.compare_buf[1];
        OFS_CAPTURE_TOP: state_next.rdata[CNT_W-1:0] = state_reg.capture_top_value;
        OFS_COUNTER: state_next.rdata[CNT_W-1:0] = state_reg.counter_value;
        OFS_FLAGS: state_next.rdata[FLG_W-1:0] = state_reg.flags;
        default: state_next.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= '0;
      state_reg.count_up <= 1'b1;
      state_reg.compare_output_state <= '0; // [R21]
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign pin_a_out = state_reg.compare_output_state[0];
  assign pin_b_out = state_reg.compare_output_state[1];
  assign pin_a_oe = state_reg.pin_oe[0];
  assign pin_b_oe = state_reg.pin_oe[1];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence fast_top_s;
    timer_tick && is_fast && at_top;
  endsequence

  sequence phase_peak_s;
    timer_tick && is_phase && at_top && state_reg.count_up;
  endsequence

  fast_wrap_a: assert property (fast_top_s |=> state_reg.counter_value == COUNT_ZERO) // [R1]
    else $error("fast counter did not restart after TOP");
  fast_ovf_a: assert property (fast_top_s |=> state_reg.flags[FLG_OVERFLOW]) // [R4]
    else $error("overflow flag missing at fast TOP");
  fast_load_a: assert property (fast_top_s |=> // [R8]
      state_reg.compare_value[1] == $past(state_reg.compare_buf[1]))
    else $error("compare buffer not loaded at fast TOP");
  phase_turn_a: assert property (phase_peak_s |=>
      !state_reg.count_up && state_reg.counter_value == $past(top_value) - COUNT_ONE) // [R15]
    else $error("phase counter did not turn at TOP");
  phase_count_zero_a: assert property (timer_tick && is_phase && at_zero && !state_reg.count_up
      |=> state_reg.flags[FLG_OVERFLOW] && state_reg.count_up) // [R17]
    else $error("phase overflow or turn missing at zero");
  match_flag_a: assert property (timer_tick && hit[1] |=> state_reg.flags[FLG_CMP_LSB + 1]) // [R5]
    else $error("compare flag not set on match");
  pin_gate_a: assert property (!state_next.pin_direction_bit[0] |=> !pin_a_oe) // [R13]
    else $error("pin driven with direction set to input");
  tick_hold_a: assert property (!timer_tick |=> $stable(state_reg.counter_value)) // [R23]
    else $error("counter moved without timer tick");
  mask_write_a: assert property (reg_wr && reg_addr == OFS_CMP_B && write_mask == TOP_8BIT // [R6]
      |=> (state_reg.compare_buf[1] & ~TOP_8BIT) == COUNT_ZERO)
    else $error("compare B bits above fixed resolution kept");
  mask_keep_a: assert property (reg_wr && reg_addr == OFS_CMP_A && write_mask == TOP_8BIT
      |=> (state_reg.compare_buf[0] & ~TOP_8BIT) == COUNT_ZERO) // [R6]
    else $error("compare bits above fixed resolution kept");
  hold_none_a: assert property (state_reg.compare_output_action[1] == ACT_NONE && !reg_wr
      |=> $stable(state_reg.compare_output_state[1])) // [R22]
    else $error("output changed with no action selected");

endmodule

`default_nettype wire

/* File: testbench/pin_load.sv */
// Port pin load seen by the two compare outputs.
// Assumes no pull resistor: an undriven pin shows the opposite of the last driven level.
`timescale 1ns/1ps
`default_nettype none

module pin_load
(
  input wire logic clk,
  input wire logic drv,
  input wire logic en,
  output logic level
);
  // ---------------------------------------------------------------
  // Wire level
  // ---------------------------------------------------------------
  logic last_reg = 1'b0;
  always @(posedge clk)
  begin
    if (en)
    begin
      last_reg <= drv;
    end
  end
  // A stale copy would hide a missing enable, so the floating pin flips
  assign level = en ? drv : ~last_reg;
endmodule

`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the PWM timer: integer model compared every cycle.
// Assumes the package map and a one-cycle registered read port.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pwm_timer_pkg::*;
  // ---------------------------------------------------------------
  // Signals and model state
  // ---------------------------------------------------------------
  logic core_clk = 1'b0, sys_rst = 1'b1, timer_tick = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata;
  logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, lvl_a, lvl_b;
  logic [31:0] seed = 32'd6344;
  int bad_count = 0, samples_checked = 0;
  int mode, cnt, up, flags, cap, hold, rexp, set;
  int act[2], bufc[2], cmp[2], outs[2], dir[2];

  pwm_timer i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .timer_tick(timer_tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
    .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));
  pin_load i_pin_a (.clk(core_clk), .drv(pin_a_out), .en(pin_a_oe), .level(lvl_a));
  pin_load i_pin_b (.clk(core_clk), .drv(pin_b_out), .en(pin_b_oe), .level(lvl_b));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int is_fast(int m);
    return m == 5 || m == 6 || m == 7 || m == 14 || m == 15;
  endfunction

  function automatic int is_pc(int m);
    return m == 1 || m == 2 || m == 3 || m == 10 || m == 11;
  endfunction

  function automatic int top_of(int m);
    case (m)
      1, 5: return 255;
      2, 6: return 511;
      3, 7: return 1023;
      10, 14: return cap;
      11, 15: return cmp[0];
      default: return 65535;
    endcase
  endfunction

  function automatic int oe_of(int c);
    return dir[c] && (act[c] >= 2 || (c == 0 && act[c] == 1 && (mode == 11 || mode == 15)));
  endfunction

  function automatic int rd_val(int a);
    case (a)
      0: return mode | act[0] << 4 | act[1] << 6 | dir[0] << 8 | dir[1] << 9;
      4: return bufc[0];
      8: return bufc[1];
      12: return cap;
      16: return cnt;
      20: return flags;
      default: return 0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // Reference model, one timer tick
  // ---------------------------------------------------------------
  task automatic step();
    int t, f, rising;
    t = top_of(mode);
    f = is_fast(mode);
    if (!f && !is_pc(mode))
      return;
    rising = f ? 1 : (cnt == t) ? 0 : (cnt == 0) ? 1 : up;
    for (int c = 0; c < 2; c++)
    begin
      if (cnt == cmp[c])
      begin
        set |= 4 << c;
        if (act[c] == 1 && c == 0 && (mode == 11 || mode == 15))
          outs[0] ^= 1;
        if (act[c] == 2)
          outs[c] = f ? 0 : !rising;
        if (act[c] == 3)
          outs[c] = f ? 1 : rising;
      end
    end
    if (cnt == t)
    begin
      if (mode == 10 || mode == 14)
        set |= 2;
      cmp = bufc;
    end
    if (f)
    begin
      if (cnt == t)
      begin
        set |= 1;
        cnt = 0;
        for (int c = 0; c < 2; c++)
          if (act[c] >= 2)
            outs[c] = (act[c] == 2);
      end
      else
        cnt = (cnt + 1) & 65535;
    end
    else
    begin
      // Overflow only on the turn at zero, not on the start from reset
      if (cnt == 0 && !up)
        set |= 1;
      up = rising;
      cnt = rising ? cnt + 1 : cnt - 1;
    end
  endtask

  task automatic mwrite(int a, int d);
    int v;
    case (a)
      0:
      begin
        mode = d & 15;
        act[0] = (d >> 4) & 3;
        act[1] = (d >> 6) & 3;
        dir[0] = (d >> 8) & 1;
        dir[1] = (d >> 9) & 1;
        hold = 2;
      end
      4, 8:
      begin
        v = d & 65535;
        if (is_pc(mode) && mode < 4 || is_fast(mode) && mode < 8)
          v &= top_of(mode);
        bufc[a == 8] = v;
        if (!is_fast(mode) && !is_pc(mode))
          cmp[a == 8] = v;
      end
      12: cap = d & 65535;
      20: flags &= ~d;
      default: ;
    endcase
  endtask

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      {mode, cnt, flags, cap, rexp} = '0;
      up = 1;
      hold = 2;
      act = '{0, 0};
      bufc = '{0, 0};
      cmp = '{0, 0};
      outs = '{0, 0};
      dir = '{0, 0};
    end
    else
    begin
      rexp = reg_rd ? rd_val(int'(reg_addr)) : 0;
      set = 0;
      if (timer_tick)
        step();
      if (reg_wr)
        mwrite(int'(reg_addr), int'(reg_wdata));
      flags |= set;
      if (hold > 0)
        hold--;
    end
  end

  always @(negedge core_clk)
  begin
    if (!sys_rst)
    begin
      chk(reg_rdata, 32'(rexp));
      if (hold == 0)
      begin
        chk(32'(pin_a_oe), 32'(oe_of(0)));
        chk(32'(pin_b_oe), 32'(oe_of(1)));
        chk(32'(pin_a_out), 32'(outs[0]));
        chk(32'(pin_b_out), 32'(outs[1]));
        if (pin_a_oe === 1'b1)
          chk(32'(lvl_a), 32'(outs[0]));
        if (pin_b_oe === 1'b1)
          chk(32'(lvl_b), 32'(outs[1]));
      end
    end
  end

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  task automatic cyc(int n, int rt);
    logic [31:0] r;
    repeat (n)
    begin
      @(posedge core_clk);
      r = xs();
      timer_tick <= rt ? r[0] : 1'b1;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (r[4:1] == 4'h0)
      begin
        reg_rd <= 1'b1;
        reg_addr <= {3'h0, r[7:5], 2'h0};
      end
      else if (r[9:5] == 5'h01)
      begin
        reg_wr <= 1'b1;
        reg_addr <= OFS_FLAGS;
        reg_wdata <= {28'h0, r[13:10]};
      end
    end
  endtask

  task automatic wr(logic [7:0] a, int d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= 32'(d);
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic scen(int m, int aa, int ab, int ca, int cb, int cp, int dr, int n, int rt);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    wr(OFS_CAPTURE_TOP, cp);
    wr(OFS_CMP_A, ca);
    wr(OFS_CMP_B, cb);
    wr(OFS_CONTROL, m | aa << 4 | ab << 6 | dr << 8);
    cyc(n, rt);
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    // Scenarios take about 79k cycles; the limit stops the run at 95k cycles
    #950000;
    bad_count++;
    summarize();
  end

  initial
  begin
    int modes[4] = '{2, 3, 6, 7};
    scen(5, 2, 3, 'h10, 'h80, 0, 3, 300, 0);
    wr(OFS_CMP_B, 'h1FF0);
    wr(OFS_CMP_A, 'h1F20);
    wr(OFS_COUNTER, 'h55);
    wr(8'h24, 'h1);
    cyc(600, 1);
    wr(OFS_CONTROL, 'h2C5);
    cyc(600, 1);
    scen(14, 2, 3, 0, 'h6, 'h20, 3, 300, 1);
    for (int i = 0; i < 40 && cnt < 16; i++)
      cyc(1, 0);
    wr(OFS_CAPTURE_TOP, 8);
    cyc(66000, 0);
    scen(15, 1, 2, 5, 3, 0, 3, 200, 1);
    wr(OFS_CMP_A, 7);
    cyc(200, 0);
    scen(1, 2, 3, 'h40, 0, 0, 3, 1200, 1);
    scen(10, 3, 2, 'h10, 3, 'h10, 3, 300, 1);
    scen(11, 1, 2, 6, 2, 0, 3, 300, 1);
    wr(OFS_CMP_B, 5);
    cyc(200, 0);
    foreach (modes[i])
      scen(modes[i], 2, 0, 'h100, 'h50, 0, i, 2100, 0);
    summarize();
  end
endmodule

`default_nettype wire
